// >>> sdsp_port.sv
// How it works
// (R1) strap picks the TDM slot group
// (R2) host gives each device unique strap
// (R3) high/open/low/res-high pick groups; res-low PDM
// (R4) I2S: clock on marker pin, select on bclk
// (R5) I2S and left-justified, optional rail byte
// (R6) low-power I2S: 32 to 48 kHz, 32x
// (R7) other modes: 16 to 48 kHz, 64x
// (R8) I2S strap decode table
// (R9) PDM needs res-low strap and 2-6.144 MHz
// (R10) PDM: current stream on rising edge
// (R11) marker pin picks voltage or rail stream
// (R12) TDM: 16-bit slots, frames of 4..16
// (R13) one-bit marker pulse starts slot 1
// (R14) voltage, current, rail; fourth slot released
// (R15) msb first; rail byte in upper bits
// (R16) strap latched once clock valid, held
`include "sdsp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sdsp_port #(
  parameter int WIN_CYC = `SDSP_WIN_CYC,
  parameter int LOCK_EDGES = `SDSP_LOCK_EDGES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bclk_pin,
  input wire logic frame_marker_pin,
  input wire sdsp_pkg::sdsp_strap_t strap_level,
  output logic sdata_out,
  output logic sdata_oe_n
);
  import sdsp_pkg::*;

  // pdm range bounds follow the window length in use, not only the default
  localparam int WIN_NS = WIN_CYC * `SDSP_PCLK_NS;
  localparam logic [7:0] MIN_TGL =
    8'((`SDSP_PDM_MIN_KHZ * WIN_NS / 1000000 + `SDSP_ACT_DIV - 1) / `SDSP_ACT_DIV);
  localparam logic [7:0] MAX_TGL = 8'((`SDSP_PDM_MAX_KHZ * WIN_NS / 1000000) / `SDSP_ACT_DIV);

  // strap decode for both interface families
  function automatic sdsp_mode_t decode_mode(input logic i2s, input sdsp_strap_t s);
    sdsp_mode_t m;
    m = LM_TDM;
    if (i2s) begin
      unique case (s)
        STRAP_HIGH: m = LM_I2S;
        STRAP_OPEN: m = LM_LJ;
        STRAP_RES_HIGH: m = LM_LJ_RAIL;
        STRAP_RES_LOW: m = LM_I2S_LP;
        default: m = LM_I2S_RAIL;
      endcase
    end else if (s == STRAP_RES_LOW) begin
      m = LM_PDM;
    end
    return m;
  endfunction : decode_mode

  // first-order modulator step, two's-complement input turned offset-binary
  function automatic logic [16:0] sd_step(input logic [15:0] acc, input logic [15:0] w);
    return {1'b0, acc} + {1'b0, ~w[15], w[14:0]};
  endfunction : sd_step

  ////////////////////////////////////////////////////////////////////////////
  // apb register file

  logic ctrl_i2s_reg;
  logic [15:0] volt_reg, curr_reg;
  logic [7:0] rail_reg;
  logic [15:0] volt_sh_reg, curr_sh_reg;
  logic [7:0] rail_sh_reg;
  logic req_tgl_reg;
  logic ack_meta, ack_sync;
  logic busy;
  logic clk_active_reg, pdm_ok_reg;
  logic [8:0] stat_meta, stat_sync;
  logic [31:0] prdata_reg;
  logic wr_en, mapped;

  assign mapped = (paddr == `SDSP_OFF_CTRL) || (paddr == `SDSP_OFF_VOLT) ||
                  (paddr == `SDSP_OFF_CURR) || (paddr == `SDSP_OFF_RAIL) ||
                  (paddr == `SDSP_OFF_STAT);
  assign wr_en = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign busy = req_tgl_reg != ack_sync;

  // sample registers; clock routing bit must only change with clocks stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_i2s_reg <= `SDSP_CTRL_I2S_RST;
      volt_reg <= `SDSP_WORD_RST;
      curr_reg <= `SDSP_WORD_RST;
      rail_reg <= `SDSP_RAIL_RST;
    end else if (wr_en) begin
      if (paddr == `SDSP_OFF_CTRL) ctrl_i2s_reg <= pwdata[`SDSP_CTRL_I2S];
      if (paddr == `SDSP_OFF_VOLT) volt_reg <= pwdata[15:0];
      if (paddr == `SDSP_OFF_CURR) curr_reg <= pwdata[15:0];
      if (paddr == `SDSP_OFF_RAIL) rail_reg <= pwdata[7:0];
    end
  end

  // commit: shadow stays frozen until the link side acknowledges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_sh_reg <= `SDSP_WORD_RST;
      curr_sh_reg <= `SDSP_WORD_RST;
      rail_sh_reg <= `SDSP_RAIL_RST;
      req_tgl_reg <= 1'b0;
    end else if (wr_en && paddr == `SDSP_OFF_CTRL && pwdata[`SDSP_CTRL_COMMIT] && !busy) begin
      volt_sh_reg <= volt_reg;
      curr_sh_reg <= curr_reg;
      rail_sh_reg <= rail_reg;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // read data taken in the setup phase, valid through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_reg <= 32'h0000_0000;
      if (paddr == `SDSP_OFF_CTRL) prdata_reg[`SDSP_CTRL_I2S] <= ctrl_i2s_reg;
      if (paddr == `SDSP_OFF_VOLT) prdata_reg[15:0] <= volt_reg;
      if (paddr == `SDSP_OFF_CURR) prdata_reg[15:0] <= curr_reg;
      if (paddr == `SDSP_OFF_RAIL) prdata_reg[7:0] <= rail_reg;
      if (paddr == `SDSP_OFF_STAT) begin
        prdata_reg[`SDSP_STAT_ACTIVE] <= clk_active_reg;
        prdata_reg[`SDSP_STAT_PDM_OK] <= pdm_ok_reg;
        prdata_reg[`SDSP_STAT_BUSY] <= busy;
        prdata_reg[`SDSP_STAT_LOCKED] <= stat_sync[0];
        prdata_reg[`SDSP_STAT_MODE_HI:`SDSP_STAT_MODE_LO] <= stat_sync[3:1];
        prdata_reg[`SDSP_STAT_FALL_V] <= stat_sync[4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link clock supervision in the pclk domain

  logic act_tgl;
  // link-side state read back here, declared ahead of its first use
  logic req_seen_reg, locked_reg, fall_v_reg;
  sdsp_mode_t mode_reg;
  logic act_meta, act_sync, act_prev;
  logic [12:0] win_cnt_reg;
  logic [7:0] tgl_cnt_reg;

  // level signals coming back from the link side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      act_meta <= 1'b0;
      act_sync <= 1'b0;
      act_prev <= 1'b0;
      stat_meta <= '0;
      stat_sync <= '0;
    end else begin
      ack_meta <= req_seen_reg;
      ack_sync <= ack_meta;
      act_meta <= act_tgl;
      act_sync <= act_meta;
      act_prev <= act_sync;
      stat_meta <= {4'h0, fall_v_reg, mode_reg, locked_reg};
      stat_sync <= stat_meta;
    end
  end

  // count divided link toggles per window; zero means the clock has stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_reg <= '0;
      tgl_cnt_reg <= '0;
      clk_active_reg <= 1'b0;
      pdm_ok_reg <= 1'b0;
    end else if (win_cnt_reg == 13'(WIN_CYC - 1)) begin
      win_cnt_reg <= '0;
      tgl_cnt_reg <= '0;
      clk_active_reg <= tgl_cnt_reg != 8'h00;
      pdm_ok_reg <= tgl_cnt_reg >= MIN_TGL && tgl_cnt_reg <= MAX_TGL; // R9
    end else begin
      win_cnt_reg <= win_cnt_reg + 13'h0001;
      if (act_sync != act_prev && tgl_cnt_reg != 8'hff) tgl_cnt_reg <= tgl_cnt_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain

  logic link_clk, frame_in;
  logic lrst_meta, lrst_n;
  logic [2:0] lvl_meta, lvl_sync;
  logic [3:0] pin_meta, pin_sync;
  logic i2s_s, idle_s, pdm_ok_s;
  logic req_meta, req_sync;
  logic [15:0] v_w, i_w;
  logic [7:0] r_w;
  logic [2:0] div_reg;
  logic [2:0] strap_prev;
  logic [2:0] lock_cnt;
  logic [1:0] group_reg;

  // pin roles swap in the i2s family
  assign link_clk = ctrl_i2s_reg ? frame_marker_pin : bclk_pin; // R4
  assign frame_in = i2s_s ? bclk_pin : frame_marker_pin; // R4
  assign i2s_s = lvl_sync[0];
  assign idle_s = lvl_sync[1];
  assign pdm_ok_s = lvl_sync[2];

  // reset released on the link clock
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_meta <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_n <= lrst_meta;
    end
  end

  // two-flop synchronisers for levels and static pins
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lvl_meta <= 3'h2;
      lvl_sync <= 3'h2;
      pin_meta <= '0;
      pin_sync <= '0;
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end else begin
      lvl_meta <= {pdm_ok_reg, !clk_active_reg, ctrl_i2s_reg};
      lvl_sync <= lvl_meta;
      pin_meta <= {frame_marker_pin, strap_level};
      pin_sync <= pin_meta;
      req_meta <= req_tgl_reg;
      req_sync <= req_meta;
    end
  end

  // activity divider seen by the supervisor
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      div_reg <= '0;
      act_tgl <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      if (div_reg == 3'h7) act_tgl <= ~act_tgl;
    end
  end

  // sample words loaded on each new request, acknowledged by toggle
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      v_w <= `SDSP_WORD_RST;
      i_w <= `SDSP_WORD_RST;
      r_w <= `SDSP_RAIL_RST;
      req_seen_reg <= 1'b0;
    end else if (req_sync != req_seen_reg) begin
      v_w <= volt_sh_reg;
      i_w <= curr_sh_reg;
      r_w <= rail_sh_reg;
      req_seen_reg <= req_sync;
    end
  end

  // strap latched after it stays stable; released on the first link edges after a stop is reported
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      locked_reg <= 1'b0;
      lock_cnt <= '0;
      strap_prev <= '0;
      mode_reg <= LM_TDM;
      group_reg <= 2'h0;
      fall_v_reg <= 1'b0;
    end else if (idle_s) begin
      locked_reg <= 1'b0; // R16
      lock_cnt <= '0;
    end else if (!locked_reg) begin
      strap_prev <= pin_sync[2:0];
      lock_cnt <= (pin_sync[2:0] != strap_prev) ? 3'h0 : lock_cnt + 3'h1;
      if (lock_cnt == 3'(LOCK_EDGES - 1)) begin
        locked_reg <= 1'b1; // R16
        mode_reg <= decode_mode(i2s_s, sdsp_strap_t'(pin_sync[2:0])); // R3 R8
        fall_v_reg <= pin_sync[3]; // R11
        unique case (sdsp_strap_t'(pin_sync[2:0]))
          STRAP_HIGH: group_reg <= 2'h0; // R1
          STRAP_OPEN: group_reg <= 2'h1;
          STRAP_LOW: group_reg <= 2'h2;
          default: group_reg <= 2'h3;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial framing for tdm and i2s styles

  logic fr_q;
  logic [7:0] cnt_reg, cnt_next, pos;
  logic ser_bit_reg, ser_drv_reg, bit_next, drv_next;
  logic [15:0] word;
  logic is_ser, is_i2s_style, rail_app;

  assign is_ser = locked_reg && mode_reg != LM_PDM;
  assign is_i2s_style = mode_reg == LM_I2S || mode_reg == LM_I2S_RAIL ||
                        mode_reg == LM_I2S_LP; // R6
  assign rail_app = mode_reg == LM_LJ_RAIL || mode_reg == LM_I2S_RAIL;

  // next bit position and data bit, msb first
  always_comb begin
    cnt_next = (cnt_reg == 8'hff) ? cnt_reg : cnt_reg + 8'h01;
    bit_next = 1'b0;
    drv_next = 1'b0;
    word = 16'h0000;
    pos = 8'h00;
    if (mode_reg == LM_TDM) begin
      if (frame_in && !fr_q) cnt_next = 8'h00; // R13
      unique case (cnt_next[5:4])
        2'h0: word = v_w; // R14
        2'h1: word = i_w;
        2'h2: word = {r_w, 8'h00}; // R15
        default: word = 16'h0000;
      endcase
      drv_next = is_ser && cnt_next[7:6] == group_reg && cnt_next[5:4] != 2'h3; // R1 R12 R14
      bit_next = word[~cnt_next[3:0]]; // R15
    end else begin
      if (frame_in != fr_q) cnt_next = 8'h00;
      pos = is_i2s_style ? cnt_next - 8'h01 : cnt_next; // R5
      word = frame_in ? i_w : v_w;
      drv_next = is_ser;
      if (pos < 8'd16) bit_next = word[~pos[3:0]]; // R5
      else if (rail_app && !frame_in && pos < 8'd24) bit_next = r_w[~pos[2:0]]; // R5
    end
  end

  // outputs launched right after the rising edge
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      fr_q <= 1'b0;
      cnt_reg <= 8'hff;
      ser_bit_reg <= 1'b0;
      ser_drv_reg <= 1'b0;
    end else begin
      fr_q <= frame_in;
      cnt_reg <= cnt_next;
      ser_bit_reg <= bit_next;
      ser_drv_reg <= drv_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pdm streams, one per clock edge

  logic [15:0] acc_r, acc_f;
  logic rise_bit, fall_bit, pdm_act;
  logic [16:0] step_r, step_f;

  assign pdm_act = locked_reg && mode_reg == LM_PDM && pdm_ok_s; // R9
  assign step_r = sd_step(acc_r, i_w);
  assign step_f = sd_step(acc_f, fall_v_reg ? v_w : {r_w, 8'h00});

  // current stream, rising edge
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      acc_r <= '0;
      rise_bit <= 1'b0;
    end else begin
      acc_r <= step_r[15:0];
      rise_bit <= step_r[16]; // R10
    end
  end

  // voltage or rail stream, falling edge
  always_ff @(negedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      acc_f <= '0;
      fall_bit <= 1'b0;
    end else begin
      acc_f <= step_f[15:0];
      fall_bit <= step_f[16]; // R11
    end
  end

  // pdm mux follows the clock level, a small glitch risk traded for no extra clock
  assign sdata_out = pdm_act ? (link_clk ? rise_bit : fall_bit) : ser_bit_reg; // R10
  assign sdata_oe_n = pdm_act ? 1'b0 : !ser_drv_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_fourth_slot_free;
    @(posedge link_clk) disable iff (!lrst_n)
      (locked_reg && mode_reg == LM_TDM && cnt_reg[5:4] == 2'h3) |-> sdata_oe_n;
  endproperty
  a_fourth_slot_free: assert property (p_fourth_slot_free) else $error("fourth slot driven"); // R14

  property p_frame_start;
    @(posedge link_clk) disable iff (!lrst_n)
      (locked_reg && mode_reg == LM_TDM && frame_in && !fr_q) |=> cnt_reg == 8'h00;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("slot 1 not started"); // R13

  property p_own_group;
    @(posedge link_clk) disable iff (!lrst_n)
      (mode_reg == LM_TDM && !sdata_oe_n) |-> cnt_reg[7:6] == group_reg;
  endproperty
  a_own_group: assert property (p_own_group) else $error("foreign slot driven"); // R1

  property p_mode_held;
    @(posedge link_clk) disable iff (!lrst_n)
      locked_reg ##1 locked_reg |-> $stable(mode_reg) && $stable(group_reg);
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode changed while locked"); // R16

  property p_rail_low_zero;
    @(posedge link_clk) disable iff (!lrst_n)
      (mode_reg == LM_TDM && !sdata_oe_n && cnt_reg[5:4] == 2'h2 && cnt_reg[3])
        |-> !sdata_out;
  endproperty
  a_rail_low_zero: assert property (p_rail_low_zero) else $error("rail low bits set"); // R15

  property p_pdm_gated;
    @(posedge link_clk) disable iff (!lrst_n)
      (locked_reg && mode_reg == LM_PDM && !pdm_ok_s) |-> sdata_oe_n;
  endproperty
  a_pdm_gated: assert property (p_pdm_gated) else $error("pdm out of clock range"); // R9

  property p_lj_msb;
    @(posedge link_clk) disable iff (!lrst_n)
      (locked_reg && mode_reg == LM_LJ && frame_in != fr_q)
        |=> sdata_out == (fr_q ? $past(i_w[15]) : $past(v_w[15]));
  endproperty
  a_lj_msb: assert property (p_lj_msb) else $error("left-justified msb wrong"); // R5

  property p_i2s_delay;
    @(posedge link_clk) disable iff (!lrst_n)
      (locked_reg && mode_reg == LM_I2S && frame_in != fr_q)
        |=> cnt_reg == 8'h00 && !sdata_out && !sdata_oe_n;
  endproperty
  a_i2s_delay: assert property (p_i2s_delay) else $error("i2s delay slot wrong"); // R5

  c_tdm_frame: cover property (@(posedge link_clk) locked_reg && mode_reg == LM_TDM &&
                               frame_in && !fr_q);
  c_i2s_word: cover property (@(posedge link_clk) locked_reg && is_i2s_style &&
                              frame_in != fr_q);
  c_pdm_run: cover property (@(posedge link_clk) pdm_act);
  c_commit: cover property (@(posedge pclk) busy ##1 !busy);

endmodule : sdsp_port

`default_nettype wire

// >>> sdsp_regs.svh
`ifndef SDSP_REGS_SVH
`define SDSP_REGS_SVH

// register byte offsets
`define SDSP_OFF_CTRL 12'h000
`define SDSP_OFF_VOLT 12'h004
`define SDSP_OFF_CURR 12'h008
`define SDSP_OFF_RAIL 12'h00c
`define SDSP_OFF_STAT 12'h010

// control fields
`define SDSP_CTRL_I2S 0
`define SDSP_CTRL_COMMIT 1

// status fields
`define SDSP_STAT_ACTIVE 0
`define SDSP_STAT_PDM_OK 1
`define SDSP_STAT_BUSY 2
`define SDSP_STAT_LOCKED 3
`define SDSP_STAT_MODE_LO 4
`define SDSP_STAT_MODE_HI 6
`define SDSP_STAT_FALL_V 8

// reset values
`define SDSP_CTRL_I2S_RST 1'b0
`define SDSP_WORD_RST 16'h0000
`define SDSP_RAIL_RST 8'h00

// timing
`define SDSP_PCLK_NS 25
`define SDSP_WIN_NS 100000
`define SDSP_WIN_CYC (`SDSP_WIN_NS / `SDSP_PCLK_NS)
`define SDSP_ACT_DIV 8
`define SDSP_PDM_MIN_KHZ 2000
`define SDSP_PDM_MAX_KHZ 6144
`define SDSP_PDM_MIN_TGL \
  ((`SDSP_PDM_MIN_KHZ * (`SDSP_WIN_NS / 1000) / 1000 + `SDSP_ACT_DIV - 1) / `SDSP_ACT_DIV)
`define SDSP_PDM_MAX_TGL \
  ((`SDSP_PDM_MAX_KHZ * (`SDSP_WIN_NS / 1000) / 1000) / `SDSP_ACT_DIV)
`define SDSP_LOCK_EDGES 4

`endif

// >>> sdsp_pkg.sv
package sdsp_pkg;

  // five-level strap as reported by the level detector
  typedef enum logic [2:0] {
    STRAP_HIGH = 3'h0,
    STRAP_OPEN = 3'h1,
    STRAP_LOW = 3'h2,
    STRAP_RES_HIGH = 3'h3,
    STRAP_RES_LOW = 3'h4
  } sdsp_strap_t;

  // decoded output style
  typedef enum logic [2:0] {
    LM_TDM = 3'h0,
    LM_PDM = 3'h1,
    LM_I2S = 3'h2,
    LM_LJ = 3'h3,
    LM_LJ_RAIL = 3'h4,
    LM_I2S_RAIL = 3'h5,
    LM_I2S_LP = 3'h6
  } sdsp_mode_t;

endpackage : sdsp_pkg

// >>> sdsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// far-end processor: makes the link clock and framing, captures the data line
module sdsp_host_model (
  input wire logic run,
  input wire logic i2s,
  input wire logic sdata_out,
  input wire logic sdata_oe_n,
  output logic bclk_pin,
  output logic frame_marker_pin
);
  logic ck = 1'b0;
  logic marker = 1'b0;
  logic ws = 1'b0;
  logic last = 1'b0;
  logic line;
  int pos = 256;
  int flen;
  logic [15:0] rx_word [16];
  logic [15:0] rx_rel [16];

  ////////////////////////////////////////////////////////////////////////////
  // clock stands still at 0 between runs, no free-running edges
  initial begin
    #1.3;
    forever #3 ck = run ? ~ck : 1'b0;
  end

  // 64 bits per frame in i2s, 32 per sample, full 16-slot frame in tdm
  assign flen = i2s ? 64 : 256;
  // pins swap roles in the i2s family
  assign bclk_pin = i2s ? ws : ck;
  assign frame_marker_pin = i2s ? ck : marker;
  // released line shows the inverse of the last bit, so stale data never passes
  assign line = sdata_oe_n ? ~last : sdata_out;

  ////////////////////////////////////////////////////////////////////////////
  // one-bit marker before slot 1; word select flips each half frame
  always @(negedge ck) begin
    marker <= (pos == flen);
    ws <= (pos >= 32 && pos < 64);
  end

  // sample each bit at the rising edge after its launch
  always @(posedge ck) begin
    if (pos >= 1 && pos <= flen) begin
      rx_word[(pos - 1) / 16][15 - (pos - 1) % 16] <= line;
      rx_rel[(pos - 1) / 16][15 - (pos - 1) % 16] <= sdata_oe_n;
    end
    last <= line;
    pos <= (pos >= flen) ? 1 : pos + 1;
  end
endmodule : sdsp_host_model

`default_nettype wire

// >>> sdsp_port_test.sv
`include "sdsp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sdsp_port_test;
  import sdsp_pkg::*;
  localparam int WIN = 200;
  localparam logic [15:0] VV = 16'ha53c;
  localparam logic [15:0] II = 16'h0f81;
  localparam logic [7:0] RR = 8'hc6;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bclk_pin;
  logic frame_marker_pin;
  sdsp_strap_t strap_level = STRAP_HIGH;
  logic sdata_out;
  logic sdata_oe_n;
  logic run = 1'b0;
  logic i2s = 1'b0;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  sdsp_port #(.WIN_CYC(WIN), .LOCK_EDGES(4)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bclk_pin(bclk_pin),
    .frame_marker_pin(frame_marker_pin), .strap_level(strap_level),
    .sdata_out(sdata_out), .sdata_oe_n(sdata_oe_n));

  sdsp_host_model host (.run(run), .i2s(i2s), .sdata_out(sdata_out),
    .sdata_oe_n(sdata_oe_n), .bclk_pin(bclk_pin), .frame_marker_pin(frame_marker_pin));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz bus clock and a hang guard
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    check(32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // stop the link long enough to drop lock, reconfigure, relock, commit data
  task automatic restart(input sdsp_strap_t s, input logic m);
    int n = 0;
    run <= 1'b0;
    repeat (3 * WIN) @(posedge pclk);
    strap_level <= s;
    i2s <= m;
    apb(1'b1, `SDSP_OFF_CTRL, {31'h0, m});
    run <= 1'b1;
    // a lock held over the stopped clock is stale until activity is seen again
    do begin
      apb(1'b0, `SDSP_OFF_STAT, 32'h0);
      n++;
    end while ((rd[`SDSP_STAT_ACTIVE] & rd[`SDSP_STAT_LOCKED]) !== 1'b1 && n < 300);
    check(32'(rd[`SDSP_STAT_LOCKED]), 32'h1);
    apb(1'b1, `SDSP_OFF_VOLT, {16'h0, VV});
    apb(1'b1, `SDSP_OFF_CURR, {16'h0, II});
    apb(1'b1, `SDSP_OFF_RAIL, {24'h0, RR});
    apb(1'b1, `SDSP_OFF_CTRL, {30'h0, 1'b1, m});
    n = 0;
    do begin
      apb(1'b0, `SDSP_OFF_STAT, 32'h0);
      n++;
    end while (rd[`SDSP_STAT_BUSY] !== 1'b0 && n < 300);
    check(32'(rd[`SDSP_STAT_BUSY]), 32'h0);
    repeat (300) @(posedge pclk);
  endtask : restart

  // compare captured words; released words checked for release only
  task automatic frame_chk(input logic [255:0] ed, input logic [15:0] rel, input int nw);
    for (int k = 0; k < nw; k++) begin
      check(32'(host.rx_rel[k]), {16'h0, {16{rel[k]}}});
      if (!rel[k]) check(32'(host.rx_word[k]), 32'(ed[255 - 16 * k -: 16]));
    end
  endtask : frame_chk

  ////////////////////////////////////////////////////////////////////////////
  // reset values, upper voltage bits dropped and an unmapped address
  task automatic t_regs;
    apb(1'b0, `SDSP_OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `SDSP_OFF_VOLT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `SDSP_OFF_CURR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `SDSP_OFF_RAIL, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `SDSP_OFF_VOLT, 32'hffff_1234);
    apb(1'b0, `SDSP_OFF_VOLT, 32'h0);
    check(rd, 32'h0000_1234);
    apb(1'b0, 12'h014, 32'h0);
    check(rd, 32'h0);
    check(32'(er), 32'h1);
  endtask : t_regs

  // each strap picks one slot group; a strap change while locked is ignored
  task automatic t_tdm(input sdsp_strap_t s, input int g);
    logic [255:0] ed;
    logic [15:0] rel;
    restart(s, 1'b0);
    apb(1'b0, `SDSP_OFF_STAT, 32'h0);
    check(32'(rd[6:4]), 32'(LM_TDM));
    ed = {VV, II, RR, 8'h00, 16'h0, 192'h0} >> (64 * g);
    rel = ~(16'h0007 << (4 * g));
    frame_chk(ed, rel, 16);
    strap_level <= STRAP_RES_LOW;
    repeat (300) @(posedge pclk);
    frame_chk(ed, rel, 16);
  endtask : t_tdm

  // pdm strap with a clock far above range: line stays released
  task automatic t_pdm;
    restart(STRAP_RES_LOW, 1'b0);
    apb(1'b0, `SDSP_OFF_STAT, 32'h0);
    check(32'(rd[`SDSP_STAT_PDM_OK]), 32'h0);
    frame_chk(256'h0, 16'hffff, 16);
  endtask : t_pdm

  // i2s family: one delay bit in i2s, rail byte after voltage where chosen
  task automatic t_i2s(input sdsp_strap_t s, input sdsp_mode_t md, input logic lj,
                       input logic rl);
    logic [31:0] l;
    logic [31:0] r;
    restart(s, 1'b1);
    apb(1'b0, `SDSP_OFF_STAT, 32'h0);
    check(32'(rd[6:4]), 32'(md));
    l = {VV, rl ? RR : 8'h00, 8'h00};
    r = {II, 16'h0};
    if (!lj) begin
      l = l >> 1;
      r = r >> 1;
    end
    frame_chk({l, r, 192'h0}, 16'h0000, 4);
  endtask : t_i2s

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    check(32'(sdata_oe_n), 32'h1);
    presetn <= 1'b1;
    t_regs();
    t_tdm(STRAP_HIGH, 0);
    t_tdm(STRAP_OPEN, 1);
    t_tdm(STRAP_LOW, 2);
    t_tdm(STRAP_RES_HIGH, 3);
    t_pdm();
    t_i2s(STRAP_HIGH, LM_I2S, 1'b0, 1'b0);
    t_i2s(STRAP_OPEN, LM_LJ, 1'b1, 1'b0);
    t_i2s(STRAP_RES_HIGH, LM_LJ_RAIL, 1'b1, 1'b1);
    t_i2s(STRAP_LOW, LM_I2S_RAIL, 1'b0, 1'b1);
    t_i2s(STRAP_RES_LOW, LM_I2S_LP, 1'b0, 1'b0);
    final_report();
  end
endmodule : sdsp_port_test

`default_nettype wire
